// File: design/tmr8_pkg.sv
// Package for the 8-bit timer with two compare units
package tmr8_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;

  // Control A fields
  localparam int CA_WGM0_POS = 0;
  localparam int CA_WGM1_POS = 1;
  localparam int CA_COMB_POS = 4;
  localparam int CA_COMA_POS = 6;
  // Control B fields
  localparam int CB_CS_POS = 0;
  localparam int CB_WGM2_POS = 3;
  localparam int CB_FOCB_POS = 6;
  localparam int CB_FOCA_POS = 7;
  // Flag and mask bit positions
  localparam int FL_OVF_POS = 0;
  localparam int FL_CMPA_POS = 1;
  localparam int FL_CMPB_POS = 2;

  // Reset values and extreme counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

  // Clock-select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Waveform modes
  typedef enum logic [2:0] {
    TMR8_NORMAL = 3'b000,
    TMR8_PC_PWM_FF = 3'b001,
    TMR8_CLEAR_ON_MATCH = 3'b010,
    TMR8_FAST_PWM_FF = 3'b011,
    TMR8_RSVD4 = 3'b100,
    TMR8_PC_PWM_A = 3'b101,
    TMR8_RSVD6 = 3'b110,
    TMR8_FAST_PWM_A = 3'b111
  } tmr8_mode_e;

  // Events from the counter unit
  typedef struct packed {
    logic tick;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
  } tmr8_evt_s;

endpackage

// File: design/tmr8_core.sv
// Timer core: counter, two compare units, flags and APB register file
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module tmr8_core
  import tmr8_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer clock sources
  input wire logic prescaled_tick,
  input wire logic external_count_pin,
  // Interrupt service acknowledges, one pulse each
  input wire logic ovf_serviced,
  input wire logic cmpa_serviced,
  input wire logic cmpb_serviced,
  // Outputs
  output logic compare_a_output,
  output logic compare_b_output,
  output logic overflow_irq,
  output logic compare_a_irq,
  output logic compare_b_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] timer_control_a_q;
  logic [7:0] timer_control_b_q;
  logic [7:0] count_value_q;
  logic [7:0] compare_a_value_q;
  logic [7:0] compare_b_value_q;
  logic [7:0] compare_a_buf_q;
  logic [7:0] compare_b_buf_q;
  logic [2:0] timer_flag_register_q;
  logic [2:0] timer_mask_register_q;
  logic block_q;
  logic [SYNC_STAGES-1:0] pin_sync_q;
  logic pin_prev_q;
  logic oc_a_q;
  logic oc_b_q;

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic is_pwm(input tmr8_mode_e m);
    is_pwm = m[0]; // Modes 1,3,5,7 are PWM
  endfunction

  function automatic logic is_fast(input tmr8_mode_e m);
    is_fast = (m == TMR8_FAST_PWM_FF) || (m == TMR8_FAST_PWM_A);
  endfunction

  // One compare output's next level
  function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                   input tmr8_mode_e m, input logic match,
                                   input logic at_bottom, input logic up);
    logic r;
    r = cur;
    if (!is_pwm(m))
    begin
      if (match)
      begin
        case (com)
          2'b01: r = ~cur;
          2'b10: r = 1'b0;
          2'b11: r = 1'b1;
          default: r = cur;
        endcase
      end
    end
    else if (is_fast(m))
    begin
      if (com[1] && match)
        r = com[0];
      else if (com[1] && at_bottom)
        r = ~com[0];
    end
    else if (com[1] && match)
    begin
      r = up ? com[0] : ~com[0];
    end
    oc_next = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Mode and bus decode
  tmr8_mode_e mode;
  logic [2:0] clock_select_field;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [7:0] top_value;
  logic buffered;
  logic wr_en;
  logic tick_sel;
  logic addr_ok;
  logic count_wr;
  logic ext_edge;
  logic dir_down_q;
  tmr8_evt_s evt;

  // Mode field split across the two controls
  assign mode = tmr8_mode_e'({timer_control_b_q[CB_WGM2_POS],
                              timer_control_a_q[CA_WGM1_POS],
                              timer_control_a_q[CA_WGM0_POS]});
  assign clock_select_field = timer_control_b_q[CB_CS_POS +: 3];
  assign com_a = timer_control_a_q[CA_COMA_POS +: 2];
  assign com_b = timer_control_a_q[CA_COMB_POS +: 2];
  assign buffered = is_pwm(mode);
  // Ceiling follows mode
  assign top_value = (mode == TMR8_CLEAR_ON_MATCH || mode == TMR8_PC_PWM_A ||
                      mode == TMR8_FAST_PWM_A) ? compare_a_value_q : COUNT_MAX;

  assign wr_en = psel && penable && pwrite;
  assign addr_ok = (paddr == ADDR_CONTROL_A) || (paddr == ADDR_CONTROL_B) ||
                   (paddr == ADDR_COUNT) || (paddr == ADDR_COMPARE_A) ||
                   (paddr == ADDR_COMPARE_B) || (paddr == ADDR_FLAGS) ||
                   (paddr == ADDR_MASK);
  assign count_wr = wr_en && (paddr == ADDR_COUNT);

  ////////////////////////////////////////////////////////////////////////
  // External pin synchroniser; only the second stage feeds the edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync_q <= '0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], external_count_pin};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // Tick source and edge selection
  always_comb
  begin
    ext_edge = 1'b0;
    if (clock_select_field == CS_EXT_FALL)
      ext_edge = pin_prev_q && !pin_sync_q[1];
    else if (clock_select_field == CS_EXT_RISE)
      ext_edge = !pin_prev_q && pin_sync_q[1];
    if (clock_select_field == CS_STOP)
      tick_sel = 1'b0;
    else if (clock_select_field == CS_EXT_FALL || clock_select_field == CS_EXT_RISE)
      tick_sel = ext_edge;
    else
      tick_sel = prescaled_tick;
  end

  // Extreme-value and match detection, matches suppressed while block_q is set
  assign evt.tick = tick_sel;
  assign evt.at_bottom = (count_value_q == COUNT_BOTTOM);
  assign evt.at_top = (count_value_q == top_value);
  assign evt.match_a = (count_value_q == compare_a_value_q) && !block_q;
  assign evt.match_b = (count_value_q == compare_b_value_q) && !block_q;

  ////////////////////////////////////////////////////////////////////////
  // Match blocking: set by a counter write, cleared by the next tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_q <= 1'b0;
    else if (count_wr)
      block_q <= 1'b1;
    else if (evt.tick)
      block_q <= 1'b0;
  end

  // Counter; software write beats clear and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value_q <= RESET_BYTE;
      dir_down_q <= 1'b0;
    end
    else if (count_wr)
      count_value_q <= pwdata[7:0];
    else if (evt.tick)
    begin
      if (!is_pwm(mode) || is_fast(mode))
      begin
        // Single slope: wrap to bottom after top
        dir_down_q <= 1'b0;
        if (evt.at_top || count_value_q == COUNT_MAX)
          count_value_q <= COUNT_BOTTOM;
        else
          count_value_q <= count_value_q + 8'h01;
      end
      else if (dir_down_q)
      begin
        // Dual slope turns at bottom
        if (evt.at_bottom)
        begin
          dir_down_q <= 1'b0;
          count_value_q <= count_value_q + 8'h01;
        end
        else
          count_value_q <= count_value_q - 8'h01;
      end
      else if (evt.at_top)
      begin
        dir_down_q <= 1'b1;
        count_value_q <= count_value_q - 8'h01;
      end
      else
        count_value_q <= count_value_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and mask registers; strobes are not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_a_q <= RESET_BYTE;
      timer_control_b_q <= RESET_BYTE;
      timer_mask_register_q <= 3'b000;
    end
    else if (wr_en)
    begin
      if (paddr == ADDR_CONTROL_A)
        timer_control_a_q <= pwdata[7:0];
      if (paddr == ADDR_CONTROL_B)
        timer_control_b_q <= {2'b00, pwdata[5:0]};
      if (paddr == ADDR_MASK)
        timer_mask_register_q <= pwdata[2:0];
    end
  end

  // Compare buffers and active values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_a_value_q <= RESET_BYTE;
      compare_b_value_q <= RESET_BYTE;
      compare_a_buf_q <= RESET_BYTE;
      compare_b_buf_q <= RESET_BYTE;
    end
    else
    begin
      if (wr_en && paddr == ADDR_COMPARE_A)
        compare_a_buf_q <= pwdata[7:0];
      if (wr_en && paddr == ADDR_COMPARE_B)
        compare_b_buf_q <= pwdata[7:0];
      if (!buffered)
      begin
        if (wr_en && paddr == ADDR_COMPARE_A)
          compare_a_value_q <= pwdata[7:0];
        if (wr_en && paddr == ADDR_COMPARE_B)
          compare_b_value_q <= pwdata[7:0];
      end
      else if (evt.tick && ((is_fast(mode) && evt.at_top) ||
               (!is_fast(mode) && evt.at_top && !dir_down_q)))
      begin
        compare_a_value_q <= compare_a_buf_q;
        compare_b_value_q <= compare_b_buf_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a write-one clear or service
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_flag_register_q <= 3'b000;
    else
    begin
      logic [2:0] clr;
      logic [2:0] set;
      clr = {cmpb_serviced, cmpa_serviced, ovf_serviced};
      if (wr_en && paddr == ADDR_FLAGS)
        clr = clr | pwdata[2:0];
      // Overflow at COUNT_MAX, at fast-PWM top or at dual-slope bottom
      set[FL_OVF_POS] = evt.tick && (is_pwm(mode) && !is_fast(mode) ?
                        (dir_down_q && evt.at_bottom) :
                        (count_value_q == COUNT_MAX || (is_fast(mode) && evt.at_top)));
      set[FL_CMPA_POS] = evt.tick && evt.match_a;
      set[FL_CMPB_POS] = evt.tick && evt.match_b;
      timer_flag_register_q <= (timer_flag_register_q & ~clr) | set;
    end
  end

  // Compare output states; kept across mode changes, reset to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == ADDR_CONTROL_B && !is_pwm(mode) && pwdata[CB_FOCA_POS])
        oc_a_q <= oc_next(oc_a_q, com_a, mode, 1'b1, 1'b0, 1'b1);
      else if (evt.tick)
        oc_a_q <= oc_next(oc_a_q, com_a, mode, evt.match_a, evt.at_top,
                          !dir_down_q);
      if (wr_en && paddr == ADDR_CONTROL_B && !is_pwm(mode) && pwdata[CB_FOCB_POS])
        oc_b_q <= oc_next(oc_b_q, com_b, mode, 1'b1, 1'b0, 1'b1);
      else if (evt.tick)
        oc_b_q <= oc_next(oc_b_q, com_b, mode, evt.match_b, evt.at_top, !dir_down_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer, one-wait-free; unmapped addresses raise pslverr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= READ_ZERO;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ADDR_CONTROL_A: prdata <= {24'h0000_00, timer_control_a_q};
          ADDR_CONTROL_B: prdata <= {24'h0000_00, timer_control_b_q};
          ADDR_COUNT: prdata <= {24'h0000_00, count_value_q};
          ADDR_COMPARE_A: prdata <= {24'h0000_00, buffered ? compare_a_buf_q : compare_a_value_q};
          ADDR_COMPARE_B: prdata <= {24'h0000_00, buffered ? compare_b_buf_q : compare_b_value_q};
          ADDR_FLAGS: prdata <= {29'h0000_000, timer_flag_register_q};
          ADDR_MASK: prdata <= {29'h0000_000, timer_mask_register_q};
          default: prdata <= READ_ZERO;
        endcase
      end
    end
  end

  // Registered outputs; mask gates each request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_a_output <= 1'b0;
      compare_b_output <= 1'b0;
      overflow_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
    end
    else
    begin
      compare_a_output <= oc_a_q;
      compare_b_output <= oc_b_q;
      overflow_irq <= timer_flag_register_q[FL_OVF_POS] && timer_mask_register_q[FL_OVF_POS];
      compare_a_irq <= timer_flag_register_q[FL_CMPA_POS] && timer_mask_register_q[FL_CMPA_POS];
      compare_b_irq <= timer_flag_register_q[FL_CMPB_POS] && timer_mask_register_q[FL_CMPB_POS];
    end
  end

endmodule

// File: tb/tmr8_core_sva.sv
// Checker: port-level properties of the timer core
`timescale 1ns/1ps

module tmr8_core_sva
  import tmr8_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer clock sources and services
  input wire logic prescaled_tick,
  input wire logic external_count_pin,
  input wire logic ovf_serviced,
  input wire logic cmpa_serviced,
  input wire logic cmpb_serviced,
  // Outputs
  input wire logic compare_a_output,
  input wire logic compare_b_output,
  input wire logic overflow_irq,
  input wire logic compare_a_irq,
  input wire logic compare_b_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers: zero wait, one cycle wide
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready held");
  property p_bad_addr; psel && penable && pready && paddr > ADDR_MASK |-> pslverr; endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("no slverr");
  property p_good_addr;
    psel && penable && pready && paddr <= ADDR_MASK && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_good_addr: assert property (p_good_addr) else $error("false slverr");
  property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits");

  ////////////////////////////////////////////////////////////////////////////
  // Reset, flag clearing and idle outputs
  property p_reset_out; $rose(presetn) |-> !compare_a_output && !compare_b_output; endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
  property p_flag_clear;
    psel && penable && pready && pwrite && paddr == ADDR_FLAGS && pwdata[FL_OVF_POS]
      && !prescaled_tick |-> ##2 !overflow_irq;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("ovf not cleared");
  property p_cmpa_service; cmpa_serviced && !prescaled_tick |-> ##2 !compare_a_irq; endproperty
  a_cmpa_service: assert property (p_cmpa_service) else $error("cmpa kept");
  // Window covers the pin synchroniser and the output register lag
  property p_idle_hold;
    (!psel && !prescaled_tick && $stable(external_count_pin))[*8]
      |-> $stable(compare_a_output) && $stable(compare_b_output);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("output moved idle");

  // Main scenarios reached
  cover property ($rose(overflow_irq));
  cover property ($rose(compare_b_irq));
  cover property (pslverr);
endmodule

bind tmr8_core tmr8_core_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .prescaled_tick, .external_count_pin, .ovf_serviced,
  .cmpa_serviced, .cmpb_serviced, .compare_a_output, .compare_b_output, .overflow_irq,
  .compare_a_irq, .compare_b_irq);

// File: tb/tmr8_core_bench.sv
// Bench: self-checking scenarios for the timer core
`timescale 1ns/1ps

module tmr8_core_bench
  import tmr8_pkg::*;
;
  `define CHK(nm, exp, got) \
    begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end

  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, rd_err;
  logic prescaled_tick = 0, external_count_pin = 0;
  logic ovf_serviced = 0, cmpa_serviced = 0, cmpb_serviced = 0;
  logic compare_a_output, compare_b_output, overflow_irq, compare_a_irq, compare_b_irq;
  int fails = 0, check_count = 0;

  // Clock: 25 ns period
  always #12.5 pclk = ~pclk;

  tmr8_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .prescaled_tick, .external_count_pin, .ovf_serviced, .cmpa_serviced,
    .cmpb_serviced, .compare_a_output, .compare_b_output, .overflow_irq, .compare_a_irq,
    .compare_b_irq);

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input int w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      fails++;
      report_and_stop();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    `CHK(nm, exp, rd_data[7:0])
  endtask

  // One-cycle timer tick pulses, spaced apart
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      prescaled_tick <= 1'b1;
      @(posedge pclk);
      prescaled_tick <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // Let registered outputs land before looking
  task settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_stop_ext;
    apb(1, ADDR_COUNT, 8'h33);
    tick(2);
    rchk("count stopped", ADDR_COUNT, 8'h33);
    apb(1, ADDR_CONTROL_B, {5'h00, CS_EXT_RISE});
    @(posedge pclk) external_count_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    external_count_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk("count ext", ADDR_COUNT, 8'h34);
    apb(1, ADDR_CONTROL_B, 8'h00);
    apb(0, 8'h1C, 8'h00);
    `CHK("slverr", 1'b1, rd_err)
  endtask

  task t_normal;
    apb(1, ADDR_MASK, 8'h01);
    apb(1, ADDR_COUNT, 8'hFD);
    apb(1, ADDR_CONTROL_B, 8'h01);
    tick(3);
    settle();
    `CHK("ovf irq", 1'b1, overflow_irq)
    rchk("count wrap", ADDR_COUNT, 8'h00);
    rchk("flags", ADDR_FLAGS, 8'h01);
    apb(1, ADDR_FLAGS, 8'h01);
    settle();
    `CHK("ovf cleared", 1'b0, overflow_irq)
  endtask

  task t_ctc;
    apb(1, ADDR_COMPARE_A, 8'h03);
    apb(1, ADDR_MASK, 8'h02);
    apb(1, ADDR_COUNT, 8'h00);
    apb(1, ADDR_CONTROL_A, 8'h42);
    tick(3);
    settle();
    `CHK("no early flag", 1'b0, compare_a_irq)
    tick(1);
    settle();
    `CHK("cmpa irq", 1'b1, compare_a_irq)
    `CHK("toggle out", 1'b1, compare_a_output)
    rchk("ctc clear", ADDR_COUNT, 8'h00);
    @(posedge pclk) cmpa_serviced <= 1'b1;
    @(posedge pclk) cmpa_serviced <= 1'b0;
    settle();
    `CHK("cmpa serviced", 1'b0, compare_a_irq)
  endtask

  task t_block;
    apb(1, ADDR_CONTROL_A, 8'h00);
    settle();
    `CHK("out kept", 1'b1, compare_a_output)
    apb(1, ADDR_COMPARE_B, 8'h10);
    apb(1, ADDR_MASK, 8'h04);
    apb(1, ADDR_COUNT, 8'h10);
    tick(1);
    settle();
    `CHK("match blocked", 1'b0, compare_b_irq)
    apb(1, ADDR_COUNT, 8'h0F);
    tick(2);
    settle();
    `CHK("cmpb irq", 1'b1, compare_b_irq)
    @(posedge pclk) cmpb_serviced <= 1'b1;
    @(posedge pclk) cmpb_serviced <= 1'b0;
    settle();
    `CHK("cmpb serviced", 1'b0, compare_b_irq)
    apb(1, ADDR_CONTROL_B, 8'h00);
    apb(1, ADDR_FLAGS, 8'h07);
  endtask

  task t_force;
    apb(1, ADDR_MASK, 8'h07);
    apb(1, ADDR_CONTROL_A, 8'h80);
    apb(1, ADDR_CONTROL_B, 8'h80);
    settle();
    `CHK("force clear", 1'b0, compare_a_output)
    `CHK("force no flag", 1'b0, compare_a_irq)
    apb(1, ADDR_CONTROL_A, 8'hF0);
    apb(1, ADDR_CONTROL_B, 8'hC0);
    settle();
    `CHK("force set a", 1'b1, compare_a_output)
    `CHK("force set b", 1'b1, compare_b_output)
  endtask

  task t_buffer;
    apb(1, ADDR_CONTROL_A, 8'h02);
    apb(1, ADDR_COMPARE_A, 8'h04);
    apb(1, ADDR_CONTROL_A, 8'h03);
    apb(1, ADDR_CONTROL_B, 8'h09);
    apb(1, ADDR_COMPARE_A, 8'h02);
    rchk("buffer read", ADDR_COMPARE_A, 8'h02);
    apb(1, ADDR_COUNT, 8'h00);
    tick(5);
    rchk("old top kept", ADDR_COUNT, 8'h00);
    tick(3);
    rchk("new top", ADDR_COUNT, 8'h00);
    apb(1, ADDR_CONTROL_B, 8'h00);
  endtask

  // Dual slope with top at compare A = 3: turns at top, overflow at bottom
  task t_dual;
    apb(1, ADDR_CONTROL_A, 8'h80);
    apb(1, ADDR_COMPARE_A, 8'h03);
    apb(1, ADDR_CONTROL_A, 8'h81);
    apb(1, ADDR_CONTROL_B, 8'h09);
    apb(1, ADDR_FLAGS, 8'h07);
    apb(1, ADDR_COUNT, 8'h00);
    tick(4);
    settle();
    `CHK("dual clear up", 1'b0, compare_a_output)
    rchk("dual turn", ADDR_COUNT, 8'h02);
    rchk("no top ovf", ADDR_FLAGS, 8'h02);
    tick(3);
    rchk("dual bottom", ADDR_COUNT, 8'h01);
    rchk("bottom ovf", ADDR_FLAGS, 8'h03);
    @(posedge pclk) ovf_serviced <= 1'b1;
    @(posedge pclk) ovf_serviced <= 1'b0;
    rchk("ovf serviced", ADDR_FLAGS, 8'h02);
    apb(1, ADDR_CONTROL_B, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held four cycles, then each scenario
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_stop_ext();
    t_normal();
    t_ctc();
    t_block();
    t_force();
    t_buffer();
    t_dual();
    report_and_stop();
  end
endmodule
